// file: hw/ccd_sequencer.sv
// Timing generator for the CCD link with an APB register slave.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ccd_sequencer (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link
  ccd_link_if.ctl link
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PDREAD = 2'b01,
    ST_VXFER = 2'b11,
    ST_HREAD = 2'b10
  } st_e;

  localparam int PW = 2 * ccd_pkg::CODE_W + 2;

  typedef struct packed {
    st_e st;
    logic run;
    logic [1:0] omode;
    logic [1:0] bmode;
    logic [1:0] omode_act;
    logic [1:0] bmode_act;
    logic [10:0] shut_line;
    logic [11:0] cnt;
    logic [2:0] sub;
    logic [10:0] line;
    logic [10:0] hcnt;
    logic ph;
    logic [PW-1:0] px1;
    logic [PW-1:0] px2;
    logic [10:0] pcnt;
    logic [10:0] last_pcnt;
    logic [ccd_pkg::CODE_W-1:0] last_pix;
    logic [11:0] pins;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } seq_state_s;

  seq_state_s s_ff;
  seq_state_s nxt_s;
  logic single;
  logic il;
  logic vbin;
  logic hbin;
  logic hr;
  logic p;
  logic hc0;
  logic setup;
  logic [10:0] hmax;
  logic [2:0] pd_lines;
  logic [11:0] line_clks;
  logic [ccd_pkg::CODE_W-1:0] code_a;
  logic [ccd_pkg::CODE_W-1:0] code_b;

  // ==========================================================================
  // Register decode
  function automatic logic reg_hit(input logic [7:0] a);
    return a == ccd_pkg::REG_CTRL || a == ccd_pkg::REG_SHUTTER ||
           a == ccd_pkg::REG_STATUS || a == ccd_pkg::REG_PIXCNT ||
           a == ccd_pkg::REG_LASTPIX;
  endfunction : reg_hit

  function automatic logic [31:0] reg_read(input logic [7:0] a,
                                           input seq_state_s s);
    logic [31:0] r;
    r = 32'h0;
    case (a)
      ccd_pkg::REG_CTRL: begin
        r[ccd_pkg::CTRL_RUN] = s.run;
        r[ccd_pkg::CTRL_OMODE_LSB +: 2] = s.omode;
        r[ccd_pkg::CTRL_BMODE_LSB +: 2] = s.bmode;
      end
      ccd_pkg::REG_SHUTTER: r[10:0] = s.shut_line;
      ccd_pkg::REG_STATUS: begin
        r[ccd_pkg::STATUS_STATE_LSB +: 2] = s.st;
        r[ccd_pkg::STATUS_LINE_LSB +: 11] = s.line;
      end
      ccd_pkg::REG_PIXCNT: r[10:0] = s.last_pcnt;
      ccd_pkg::REG_LASTPIX: r[ccd_pkg::CODE_W-1:0] = s.last_pix;
      default: r = 32'h0;
    endcase
    return r;
  endfunction : reg_read

  // Counts follow the frame's latched modes, never the live register.
  assign single = s_ff.omode_act == ccd_pkg::OUT_SINGLE;
  assign il = s_ff.omode_act == ccd_pkg::OUT_INTERLEAVED;
  assign vbin = s_ff.bmode_act != ccd_pkg::BIN_1X1;
  assign hbin = s_ff.bmode_act == ccd_pkg::BIN_2X2;
  assign hmax = single ? 11'(ccd_pkg::H_CNT_SINGLE) :
                11'(ccd_pkg::H_CNT_DUAL);
  assign pd_lines = single ? 3'(ccd_pkg::PD_LINES_SINGLE) :
                    3'(ccd_pkg::PD_LINES_DUAL);
  assign line_clks = 12'(ccd_pkg::H_CLKS) * 12'(hmax) +
                     12'(ccd_pkg::RETRACE_CYC);
  assign setup = psel && !penable;
  assign code_a = s_ff.px2[PW-2 -: ccd_pkg::CODE_W];
  assign code_b = s_ff.px2[ccd_pkg::CODE_W-1:0];

  // ==========================================================================
  // Sequencing
  always_comb begin
    nxt_s = s_ff;
    nxt_s.px1 = {link.pix_a_valid, link.pix_a_code,
                 link.pix_b_valid, link.pix_b_code};
    nxt_s.px2 = s_ff.px1;
    nxt_s.pready = setup;
    nxt_s.pslverr = setup && !reg_hit(paddr);
    nxt_s.prdata = (setup && !pwrite) ? reg_read(paddr, s_ff) : 32'h0;
    if (psel && penable && s_ff.pready && pwrite) begin
      if (paddr == ccd_pkg::REG_CTRL) begin
        nxt_s.run = pwdata[ccd_pkg::CTRL_RUN];
        nxt_s.omode = pwdata[ccd_pkg::CTRL_OMODE_LSB +: 2];
        nxt_s.bmode = pwdata[ccd_pkg::CTRL_BMODE_LSB +: 2];
      end
      if (paddr == ccd_pkg::REG_SHUTTER) begin
        nxt_s.shut_line = pwdata[10:0];
      end
    end
    // Real pixels only; empty cycles are discarded.
    if (s_ff.px2[PW-1] && !code_a[ccd_pkg::CODE_EMPTY]) begin
      nxt_s.last_pix = code_a;
    end
    nxt_s.pcnt = s_ff.pcnt +
      11'(s_ff.px2[PW-1] && !code_a[ccd_pkg::CODE_EMPTY]) +
      11'(s_ff.px2[ccd_pkg::CODE_W] && !code_b[ccd_pkg::CODE_EMPTY]);
    case (s_ff.st)
      ST_IDLE: begin
        if (s_ff.run) begin
          nxt_s.st = ST_PDREAD;
          nxt_s.omode_act = s_ff.omode;
          nxt_s.bmode_act = s_ff.bmode;
          nxt_s.cnt = 12'h0;
          nxt_s.sub = 3'h0;
        end
      end
      ST_PDREAD: begin
        nxt_s.cnt = s_ff.cnt + 12'h1;
        if (s_ff.cnt == line_clks - 12'h1) begin
          nxt_s.cnt = 12'h0;
          nxt_s.sub = s_ff.sub + 3'h1;
          if (s_ff.sub == pd_lines - 3'h1) begin
            nxt_s.st = ST_VXFER;
            nxt_s.line = 11'h0;
          end
        end
      end
      ST_VXFER: begin
        nxt_s.cnt = s_ff.cnt + 12'h1;
        if (s_ff.cnt == 12'(ccd_pkg::RETRACE_CYC - 1)) begin
          nxt_s.st = ST_HREAD;
          nxt_s.hcnt = 11'h0;
          nxt_s.ph = 1'b0;
          nxt_s.line = s_ff.line + (vbin ? 11'h2 : 11'h1);
          nxt_s.last_pcnt = s_ff.pcnt;
          nxt_s.pcnt = 11'h0;
        end
      end
      ST_HREAD: begin
        nxt_s.ph = ~s_ff.ph;
        if (s_ff.ph) begin
          nxt_s.hcnt = s_ff.hcnt + 11'h1;
          if (s_ff.hcnt == hmax - 11'h1) begin
            nxt_s.cnt = 12'h0;
            nxt_s.sub = 3'h0;
            if (s_ff.line < 11'(ccd_pkg::LINES_FRAME)) begin
              nxt_s.st = ST_VXFER;
            end else if (s_ff.run) begin
              nxt_s.st = ST_PDREAD;
              nxt_s.omode_act = s_ff.omode;
              nxt_s.bmode_act = s_ff.bmode;
            end else begin
              nxt_s.st = ST_IDLE;
            end
          end
        end
      end
      default: nxt_s.st = ST_IDLE;
    endcase
    // Link pins are derived from the next state so they leave a flop.
    hr = nxt_s.st == ST_HREAD;
    p = nxt_s.ph;
    hc0 = nxt_s.hcnt[0];
    nxt_s.pins[0] = nxt_s.st == ST_PDREAD && nxt_s.sub == 3'h0 &&
                    nxt_s.cnt < 12'(ccd_pkg::RETRACE_CYC);
    nxt_s.pins[1] = nxt_s.st == ST_VXFER && (nxt_s.cnt == 12'h0 ||
                    (vbin && nxt_s.cnt ==
                     12'(ccd_pkg::RETRACE_CYC / 2)));
    nxt_s.pins[2] = hr && (il ? ~p : p);
    nxt_s.pins[3] = hr && (il ? p : ~p);
    nxt_s.pins[4] = hr && p;
    nxt_s.pins[5] = hr && ~p;
    nxt_s.pins[6] = hr && (single ? ~p : p);
    nxt_s.pins[7] = hr && (single ? p : ~p);
    // 2x2 binned readout lets two shifts pile up before the gate releases.
    nxt_s.pins[8] = hr && (hbin ? (~p && hc0) : nxt_s.pins[3]);
    nxt_s.pins[9] = hr && !single && (hbin ? (~p && hc0) : ~p);
    nxt_s.pins[10] = hr && p && (hbin ? ~hc0 : 1'b1);
    nxt_s.pins[11] = nxt_s.st == ST_VXFER && nxt_s.cnt == 12'h0 &&
                     s_ff.shut_line != 11'h0 &&
                     nxt_s.line == s_ff.shut_line;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign link.pd_xfer = s_ff.pins[0];
  assign link.line_shift = s_ff.pins[1];
  assign link.horiz_first_phase_half_a = s_ff.pins[2];
  assign link.horiz_second_phase_half_a = s_ff.pins[3];
  assign link.horiz_first_phase_half_b = s_ff.pins[4];
  assign link.horiz_second_phase_half_b = s_ff.pins[5];
  assign link.horiz_first_phase_reversible = s_ff.pins[6];
  assign link.horiz_second_phase_reversible = s_ff.pins[7];
  assign link.summing_gate_a = s_ff.pins[8];
  assign link.summing_gate_b = s_ff.pins[9];
  assign link.reset_gate = s_ff.pins[10];
  assign link.shutter = s_ff.pins[11];

endmodule : ccd_sequencer
`default_nettype wire

// file: hw/ccd_pkg.sv
// Shared constants and types for the CCD readout link and its sequencer.
package ccd_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int H_PERIOD_NS = 50;
  localparam int H_CLKS = H_PERIOD_NS / CLK_PERIOD_NS;
  // Retrace time is a least time, so the cycle count rounds up.
  localparam int RETRACE_NS = 4000;
  localparam int RETRACE_CYC = (RETRACE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Geometry and per-mode counts
  localparam int H_CNT_DUAL = 532;
  localparam int H_CNT_SINGLE = 1060;
  localparam int LINES_FRAME = 1032;
  localparam int PD_LINES_DUAL = 4;
  localparam int PD_LINES_SINGLE = 2;
  localparam int EMPTY_LEAD = 2;
  localparam int DARK_COLS = 14;
  localparam int COLS_HALF = 528;
  localparam int COLS_TOTAL = 1056;
  localparam int COL_W = 11;
  localparam int CODE_W = 15;

  // Pixel code fields: {hsum, vsum, empty, dark, column}.
  localparam int CODE_HSUM = 14;
  localparam int CODE_VSUM = 13;
  localparam int CODE_EMPTY = 12;
  localparam int CODE_DARK = 11;

  // ==========================================================================
  // Modes
  typedef enum logic [1:0] {
    OUT_DUAL = 2'h0,
    OUT_INTERLEAVED = 2'h1,
    OUT_SINGLE = 2'h2
  } out_mode_e;

  typedef enum logic [1:0] {
    BIN_1X1 = 2'h0,
    BIN_1X2 = 2'h1,
    BIN_2X2 = 2'h2
  } bin_mode_e;

  // ==========================================================================
  // Sequencer registers
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SHUTTER = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PIXCNT = 8'h0c;
  localparam logic [7:0] REG_LASTPIX = 8'h10;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_OMODE_LSB = 1;
  localparam int CTRL_BMODE_LSB = 3;
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_LINE_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0;

endpackage : ccd_pkg

// file: hw/ccd_link_if.sv
// Pin-level link between the timing generator and the sensor.
`timescale 1ns/10ps
`default_nettype none
interface ccd_link_if;
  logic pd_xfer;
  logic line_shift;
  logic horiz_first_phase_half_a;
  logic horiz_second_phase_half_a;
  logic horiz_first_phase_half_b;
  logic horiz_second_phase_half_b;
  logic horiz_first_phase_reversible;
  logic horiz_second_phase_reversible;
  logic summing_gate_a;
  logic summing_gate_b;
  logic reset_gate;
  logic shutter;
  logic pix_a_valid;
  logic [ccd_pkg::CODE_W-1:0] pix_a_code;
  logic pix_b_valid;
  logic [ccd_pkg::CODE_W-1:0] pix_b_code;

  modport ctl (
    output pd_xfer, line_shift, horiz_first_phase_half_a,
    output horiz_second_phase_half_a, horiz_first_phase_half_b,
    output horiz_second_phase_half_b, horiz_first_phase_reversible,
    output horiz_second_phase_reversible, summing_gate_a, summing_gate_b,
    output reset_gate, shutter,
    input pix_a_valid, pix_a_code, pix_b_valid, pix_b_code
  );

  modport sen (
    input pd_xfer, line_shift, horiz_first_phase_half_a,
    input horiz_second_phase_half_a, horiz_first_phase_half_b,
    input horiz_second_phase_half_b, horiz_first_phase_reversible,
    input horiz_second_phase_reversible, summing_gate_a, summing_gate_b,
    input reset_gate, shutter,
    output pix_a_valid, pix_a_code, pix_b_valid, pix_b_code
  );
endinterface : ccd_link_if
`default_nettype wire

// file: hw/ccd_sensor.sv
// Behavioural digital model of the sensor's charge transport.
`timescale 1ns/10ps
`default_nettype none
module ccd_sensor (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Link
  ccd_link_if.sen link,
  // User side
  output logic frame_loaded,
  output logic exposure_restart,
  output logic [ccd_pkg::COL_W-1:0] row_index
);

  localparam int NIN = 12;

  typedef struct packed {
    logic [NIN-1:0] sy1;
    logic [NIN-1:0] sy2;
    logic [NIN-1:0] prv;
    logic charged;
    logic fresh;
    logic vsum;
    logic rev;
    logic [10:0] line_no;
    logic [10:0] a_k;
    logic [10:0] b_k;
    logic [1:0] a_acc;
    logic [1:0] b_acc;
    logic [12:0] a_pend;
    logic [12:0] b_pend;
    logic a_valid;
    logic b_valid;
    logic [ccd_pkg::CODE_W-1:0] a_code;
    logic [ccd_pkg::CODE_W-1:0] b_code;
    logic loaded;
    logic restart;
  } sen_state_s;

  sen_state_s s_ff;
  sen_state_s nxt_s;
  logic [NIN-1:0] pins;
  logic [NIN-1:0] rise;
  logic [NIN-1:0] fall;

  // ==========================================================================
  // Column decode: leading empties, dark columns, side of the register
  function automatic logic [12:0] pix_code(input logic [10:0] k,
                                           input logic rev,
                                           input logic bside,
                                           input logic charged);
    logic [10:0] j;
    logic [10:0] lim;
    logic [10:0] col;
    logic empty;
    logic dark;
    j = k - 11'(ccd_pkg::EMPTY_LEAD);
    lim = rev ? 11'(ccd_pkg::COLS_TOTAL) : 11'(ccd_pkg::COLS_HALF);
    empty = (k < 11'(ccd_pkg::EMPTY_LEAD)) || (j >= lim) || !charged;
    col = bside ? 11'(ccd_pkg::COLS_TOTAL - 1) - j : j;
    dark = (col < 11'(ccd_pkg::DARK_COLS)) ||
           (col >= 11'(ccd_pkg::COLS_TOTAL - ccd_pkg::DARK_COLS));
    return {empty, dark & ~empty, empty ? 11'h0 : col};
  endfunction : pix_code

  assign pins = {link.shutter, link.reset_gate, link.summing_gate_b,
                 link.summing_gate_a, link.horiz_second_phase_reversible,
                 link.horiz_first_phase_reversible,
                 link.horiz_second_phase_half_b,
                 link.horiz_first_phase_half_b,
                 link.horiz_second_phase_half_a,
                 link.horiz_first_phase_half_a, link.line_shift,
                 link.pd_xfer};
  assign rise = s_ff.sy2 & ~s_ff.prv;
  assign fall = ~s_ff.sy2 & s_ff.prv;

  // ==========================================================================
  // Charge transport
  always_comb begin
    nxt_s = s_ff;
    nxt_s.sy1 = pins;
    nxt_s.sy2 = s_ff.sy1;
    nxt_s.prv = s_ff.sy2;
    nxt_s.a_valid = 1'b0;
    nxt_s.b_valid = 1'b0;
    nxt_s.loaded = 1'b0;
    nxt_s.restart = 1'b0;
    if (rise[11]) begin
      nxt_s.restart = 1'b1;
    end
    if (rise[0]) begin
      nxt_s.charged = 1'b1;
      nxt_s.line_no = 11'h0;
      nxt_s.fresh = 1'b0;
      nxt_s.loaded = 1'b1;
    end
    if (rise[1]) begin
      // A second line moved in before any shift sums two rows.
      nxt_s.vsum = s_ff.fresh;
      nxt_s.fresh = 1'b1;
      nxt_s.line_no = s_ff.line_no + 11'h1;
      nxt_s.a_k = 11'h0;
      nxt_s.b_k = 11'h0;
      nxt_s.a_acc = 2'h0;
      nxt_s.b_acc = 2'h0;
    end
    // The A half only ever moves toward the A output.
    // A packet lands under the second phase as it rises; loading on the
    // first phase would collide with the gate's fall and add an empty.
    if (rise[3]) begin
      nxt_s.fresh = 1'b0;
      nxt_s.a_pend = pix_code(s_ff.a_k, s_ff.rev, 1'b0, s_ff.charged);
      nxt_s.a_k = s_ff.a_k + 11'h1;
      nxt_s.a_acc = (s_ff.a_acc == 2'h3) ? 2'h3 : s_ff.a_acc + 2'h1;
    end
    // Reversible phases in step with B mean transport toward B.
    if (rise[5]) begin
      nxt_s.rev = s_ff.sy2[7] != s_ff.sy2[5];
      if (s_ff.sy2[7] == s_ff.sy2[5]) begin
        nxt_s.fresh = 1'b0;
        nxt_s.b_pend = pix_code(s_ff.b_k, 1'b0, 1'b1, s_ff.charged);
        nxt_s.b_k = s_ff.b_k + 11'h1;
        nxt_s.b_acc = (s_ff.b_acc == 2'h3) ? 2'h3 : s_ff.b_acc + 2'h1;
      end
    end
    if (fall[8]) begin
      nxt_s.a_valid = 1'b1;
      nxt_s.a_code = {s_ff.a_acc >= 2'h2, s_ff.vsum, s_ff.a_pend};
      nxt_s.a_acc = 2'h0;
    end
    if (fall[9] && !s_ff.rev) begin
      nxt_s.b_valid = 1'b1;
      nxt_s.b_code = {s_ff.b_acc >= 2'h2, s_ff.vsum, s_ff.b_pend};
      nxt_s.b_acc = 2'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign link.pix_a_valid = s_ff.a_valid;
  assign link.pix_a_code = s_ff.a_code;
  assign link.pix_b_valid = s_ff.b_valid;
  assign link.pix_b_code = s_ff.b_code;
  assign frame_loaded = s_ff.loaded;
  assign exposure_restart = s_ff.restart;
  assign row_index = s_ff.line_no;

endmodule : ccd_sensor
`default_nettype wire

// file: testbench/ccd_link_checker.sv
// Concurrent checks on the link between sequencer and sensor.
`timescale 1ns/10ps
`default_nettype none
module ccd_link_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link pins
  input wire logic pd_xfer,
  input wire logic line_shift,
  input wire logic horiz_first_phase_half_a,
  input wire logic horiz_second_phase_half_a,
  input wire logic horiz_first_phase_half_b,
  input wire logic horiz_second_phase_half_b,
  input wire logic horiz_first_phase_reversible,
  input wire logic horiz_second_phase_reversible,
  input wire logic summing_gate_a,
  input wire logic reset_gate,
  input wire logic shutter,
  input wire logic pix_a_valid
);
  // ==========================================================================
  // Aliases and counters
  wire a1 = horiz_first_phase_half_a;
  wire a2 = horiz_second_phase_half_a;
  wire b1 = horiz_first_phase_half_b;
  wire b2 = horiz_second_phase_half_b;
  wire c1 = horiz_first_phase_reversible;
  wire c2 = horiz_second_phase_reversible;
  logic [7:0] since_ff;
  logic [11:0] hcnt_ff;
  logic [8:0] pd_len_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      since_ff <= 8'h0;
      hcnt_ff <= 12'h0;
      pd_len_ff <= 9'h0;
    end else begin
      since_ff <= line_shift ? 8'h0 : since_ff + {7'h0, since_ff != 8'hff};
      hcnt_ff <= line_shift ? 12'h0 : hcnt_ff + {11'h0, b2};
      pd_len_ff <= pd_xfer ? pd_len_ff + 9'h1 : 9'h0;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // Properties
  property p_a_two_phase; !(a1 && a2); endproperty
  a_a_two_phase: assert property (p_a_two_phase)
    else $error("A half phases overlap");
  property p_b_two_phase; !(b1 && b2); endproperty
  a_b_two_phase: assert property (p_b_two_phase)
    else $error("B half phases overlap");
  property p_rev; (c1 == b1 && c2 == b2) || (c1 != b1 && c2 != b2); endproperty
  a_rev: assert property (p_rev)
    else $error("reversible phases neither follow nor complement B");
  property p_a_link; (a1 == b1 && a2 == b2) || (a1 == b2 && a2 == b1); endproperty
  a_a_link: assert property (p_a_link)
    else $error("A phases neither equal nor half a cycle off B");
  property p_h_cycle; b2 |=> b1 && !b2; endproperty
  a_h_cycle: assert property (p_h_cycle)
    else $error("second phase not followed by first phase");
  // A binned second transfer leaves only 80 cycles before the read.
  property p_retrace; b2 |-> since_ff >= 8'd79; endproperty
  a_retrace: assert property (p_retrace)
    else $error("horizontal read inside transfer interval");
  property p_line_count;
    line_shift |-> hcnt_ff == 12'd0 || hcnt_ff == ccd_pkg::H_CNT_DUAL ||
      hcnt_ff == ccd_pkg::H_CNT_SINGLE;
  endproperty
  a_line_count: assert property (p_line_count)
    else $error("wrong horizontal cycle count per line");
  property p_pd_len; $fell(pd_xfer) |-> pd_len_ff == 9'd160; endproperty
  a_pd_len: assert property (p_pd_len)
    else $error("photodiode transfer pulse length wrong");
  property p_shutter; shutter |=> !shutter; endproperty
  a_shutter: assert property (p_shutter)
    else $error("shutter pulse longer than one cycle");
  property p_sum_pix; $fell(summing_gate_a) |-> ##3 pix_a_valid; endproperty
  a_sum_pix: assert property (p_sum_pix)
    else $error("no pixel after summing gate fell");
  property p_reset_gate; reset_gate |-> horiz_first_phase_half_b; endproperty
  a_reset_gate: assert property (p_reset_gate)
    else $error("reset gate pulsed outside second pixel half");
  c_binned: cover property (line_shift && since_ff == 8'd79);
  c_dual: cover property (line_shift && hcnt_ff == ccd_pkg::H_CNT_DUAL);
  c_single: cover property (line_shift && hcnt_ff == ccd_pkg::H_CNT_SINGLE);
  c_shutter: cover property (shutter);
endmodule : ccd_link_checker
`default_nettype wire

// file: testbench/ccd_readout_sequencing_tb_top.sv
// Self-checking bench for the sequencer and sensor pair.
`timescale 1ns/10ps
`default_nettype none
module ccd_readout_sequencing_tb_top;
  // ==========================================================================
  // Stimulus, design and checker
  logic clk, nrst, ce, psel, penable, pwrite, pready, pslverr, er;
  logic frame_loaded, exposure_restart;
  logic [7:0] paddr;
  logic [10:0] row_index;
  logic [31:0] pwdata, prdata, rd;
  int err_total, check_count, seed;
  ccd_link_if link ();
  ccd_sequencer i_ccd_sequencer (.clk(clk), .nrst(nrst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  ccd_sensor i_ccd_sensor (.clk(clk), .nrst(nrst), .ce(ce), .link(link),
    .frame_loaded(frame_loaded), .exposure_restart(exposure_restart),
    .row_index(row_index));
  ccd_link_checker i_ccd_link_checker (.clk(clk), .nrst(nrst),
    .pd_xfer(link.pd_xfer), .line_shift(link.line_shift),
    .horiz_first_phase_half_a(link.horiz_first_phase_half_a),
    .horiz_second_phase_half_a(link.horiz_second_phase_half_a),
    .horiz_first_phase_half_b(link.horiz_first_phase_half_b),
    .horiz_second_phase_half_b(link.horiz_second_phase_half_b),
    .horiz_first_phase_reversible(link.horiz_first_phase_reversible),
    .horiz_second_phase_reversible(link.horiz_second_phase_reversible),
    .summing_gate_a(link.summing_gate_a), .reset_gate(link.reset_gate),
    .shutter(link.shutter),
    .pix_a_valid(link.pix_a_valid));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================================
  // Reporting and bus tasks
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic hang(input string what);
    err_total++;
    $display("ERROR %0t: %s timed out", $time, what);
    final_report();
  endtask : hang
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask : do_reset
  // The leading edge keeps back-to-back calls from driving psel twice.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) hang("apb");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic ee);
    apb(1'b0, a, 32'h0);
    chk(rd, e, "read data");
    chk(er, ee, "slave error");
  endtask : rchk
  // ==========================================================================
  // Expected pixel code of the n-th output pixel of the A side
  function automatic logic [14:0] exp_code(input int j, input logic [1:0] om,
                                          input logic [1:0] bm);
    int col;
    logic e;
    col = j - ccd_pkg::EMPTY_LEAD;
    e = j < ccd_pkg::EMPTY_LEAD ||
      col >= (om == 2'h2 ? ccd_pkg::COLS_TOTAL : ccd_pkg::COLS_HALF);
    if (e) col = 0;
    return {bm == 2'h2, bm != 2'h0, e, !e && (col < ccd_pkg::DARK_COLS ||
      col >= ccd_pkg::COLS_TOTAL - ccd_pkg::DARK_COLS), col[10:0]};
  endfunction : exp_code
  // ==========================================================================
  // Scenarios
  task automatic reg_test();
    logic [31:0] v;
    logic [7:0] a;
    do_reset();
    rchk(ccd_pkg::REG_CTRL, ccd_pkg::CTRL_RESET, 1'b0);
    rchk(ccd_pkg::REG_SHUTTER, 32'h0, 1'b0);
    rchk(ccd_pkg::REG_STATUS, 32'h0, 1'b0);
    rchk(ccd_pkg::REG_PIXCNT, 32'h0, 1'b0);
    rchk(ccd_pkg::REG_LASTPIX, 32'h0, 1'b0);
    repeat (6) begin
      v = $random(seed);
      a = {1'b1, v[6:2], 2'h0};
      apb(1'b1, ccd_pkg::REG_SHUTTER, v);
      rchk(ccd_pkg::REG_SHUTTER, {21'h0, v[10:0]}, 1'b0);
      apb(1'b1, a, v);
      chk(er, 1'b1, "unmapped write");
      rchk(a, 32'h0, 1'b1);
    end
    $display("test registers done");
  endtask : reg_test
  task automatic run_mode(input logic [1:0] om, input logic [1:0] bm,
                          input logic [10:0] sh);
    int hmax, t, c, na, nb, nab, nreal, fl, ex, ea, e;
    int shq[$];
    logic [14:0] m;
    hmax = (om == 2'h2) ? ccd_pkg::H_CNT_SINGLE : ccd_pkg::H_CNT_DUAL;
    t = 2 * hmax + 160;
    m = (bm == 2'h2) ? 15'h6000 : 15'h7fff;
    fl = 0;
    ex = 0;
    do_reset();
    apb(1'b1, ccd_pkg::REG_SHUTTER, {21'h0, sh});
    apb(1'b1, ccd_pkg::REG_CTRL, {27'h0, bm, om, 1'b1});
    for (c = 0; link.pd_xfer !== 1'b1; c++) begin
      if (c > 200) hang("photodiode read");
      @(posedge clk);
    end
    for (c = 0; link.line_shift !== 1'b1; c++) begin
      if (c > 20000) hang("first line");
      @(posedge clk);
      fl += frame_loaded;
      ex += exposure_restart;
    end
    chk(c, ((om == 2'h2) ? 2 : 4) * t, "photodiode read");
    na = 0;
    nb = 0;
    nab = 0;
    nreal = 0;
    for (c = 1; c <= 2 * t + 170; c++) begin
      @(posedge clk);
      fl += frame_loaded;
      ex += exposure_restart;
      if (link.line_shift === 1'b1) shq.push_back(c);
      if (c >= t + 100 && c < 2 * t + 100) begin
        if (link.pix_a_valid === 1'b1) begin
          chk(link.pix_a_code & m, exp_code(na, om, bm) & m, "code");
          nreal += !link.pix_a_code[ccd_pkg::CODE_EMPTY];
          na++;
        end
        if (link.pix_b_valid === 1'b1) begin
          nreal += !link.pix_b_code[ccd_pkg::CODE_EMPTY];
          nb++;
        end
        nab += link.pix_a_valid & link.pix_b_valid;
      end
    end
    ea = (bm == 2'h2) ? hmax / 2 : hmax;
    chk(na, ea, "A pixels");
    chk(nb, (om == 2'h2) ? 0 : ea, "B pixels");
    if (bm != 2'h2) chk(nreal, ccd_pkg::COLS_TOTAL, "real pixels");
    if (om == 2'h0) chk(nab, ea, "paired pixels");
    if (om == 2'h1) chk(nab, 0, "paired pixels");
    chk(shq.size(), (bm != 2'h0) ? 5 : 2, "line transfers");
    foreach (shq[i]) begin
      e = (bm != 2'h0) ? ((i + 1) / 2) * t + 80 * (1 - i % 2) : (i + 1) * t;
      chk(shq[i], e, "transfer time");
    end
    chk(row_index, (bm != 2'h0) ? 6 : 3, "rows");
    chk(fl, 1, "frame loaded");
    chk(ex, (sh != 11'h0) ? 1 : 0, "exposure restart");
    rchk(ccd_pkg::REG_PIXCNT, nreal, 1'b0);
    apb(1'b0, ccd_pkg::REG_STATUS, 32'h0);
    chk(rd[1:0], 2'h2, "state");
    chk(rd[ccd_pkg::STATUS_LINE_LSB +: 11], (bm != 2'h0) ? 6 : 3, "line");
    rchk(ccd_pkg::REG_CTRL, {27'h0, bm, om, 1'b1}, 1'b0);
    $display("test mode %0d bin %0d done", om, bm);
  endtask : run_mode
  initial begin
    seed = 32'hb19d6f49;
    err_total = 0;
    check_count = 0;
    nrst = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    reg_test();
    run_mode(2'h0, 2'h0, 11'h1);
    run_mode(2'h1, 2'h0, 11'h0);
    run_mode(2'h2, 2'h0, 11'h0);
    run_mode(2'h0, 2'h1, 11'h0);
    run_mode(2'h0, 2'h2, 11'h0);
    final_report();
  end
endmodule : ccd_readout_sequencing_tb_top
`default_nettype wire
